//--- hw/aws_pkg.sv
// Package: constants and types for the alarm and warning supervisor
package aws_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  AWS_OFS_ALARM     = 8'h00;
    localparam logic [7:0]  AWS_OFS_WARN      = 8'h04;
    localparam logic [7:0]  AWS_OFS_CONFIG    = 8'h08;
    localparam logic [7:0]  AWS_OFS_ERR_LIMIT = 8'h0c;
    localparam logic [7:0]  AWS_OFS_TIMEOUT   = 8'h10;
    localparam logic [7:0]  AWS_OFS_DEV_ON    = 8'h14;
    localparam logic [7:0]  AWS_OFS_DEV_OFF   = 8'h18;
    localparam logic [7:0]  AWS_OFS_TEMP_LIM  = 8'h1c;
    localparam logic [7:0]  AWS_OFS_VOLT_LIM  = 8'h20;
    localparam logic [7:0]  AWS_OFS_HIST_CMD  = 8'h24;
    localparam logic [7:0]  AWS_OFS_HIST_DATA = 8'h28;
    localparam logic [7:0]  AWS_OFS_IRQ_STAT  = 8'h2c;
    localparam logic [7:0]  AWS_OFS_IRQ_MASK  = 8'h30;

    // Config register fields
    localparam int          AWS_CFG_AUTO_RET  = 0;
    localparam int          AWS_CFG_BRAKE     = 1;
    localparam int          AWS_CFG_CLEAR     = 2;

    // History command fields
    localparam int          AWS_HCMD_CLEAR    = 4;

    // Interrupt status bits
    localparam int          AWS_IRQ_ALARM     = 0;
    localparam int          AWS_IRQ_WARN      = 1;
    localparam int          AWS_IRQ_WIDTH     = 2;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  AWS_ALM_RATE      = 8'h83;
    localparam logic [7:0]  AWS_ALM_LINK_ERR  = 8'h84;
    localparam logic [7:0]  AWS_ALM_TIMEOUT   = 8'h85;
    localparam logic [7:0]  AWS_ALM_NETCONV   = 8'h8e;
    localparam logic [7:0]  AWS_WRN_DEV_ON    = 8'h10;
    localparam logic [7:0]  AWS_WRN_DEV_OFF   = 8'h12;
    localparam logic [7:0]  AWS_WRN_HEAT      = 8'h21;
    localparam logic [7:0]  AWS_WRN_VOLT      = 8'h22;
    localparam logic [3:0]  AWS_LINK_ERR_BLINKS = 4'h7;
    localparam logic [3:0]  AWS_RATE_MAX      = 4'h4;

    // ------------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------------
    localparam int          AWS_HIST_DEPTH    = 10;
    localparam int          AWS_HIST_AW       = 4;
    localparam logic [3:0]  AWS_HIST_DEPTH_C  = 4'ha;
    localparam logic [7:0]  AWS_ERR_LIMIT_RST = 8'h03;
    localparam logic [31:0] AWS_TIMEOUT_RST   = 32'h000f_4240;
    localparam logic [31:0] AWS_DEV_RST       = 32'h0000_0100;
    localparam logic [15:0] AWS_TEMP_RST      = 16'h0055;
    localparam logic [15:0] AWS_VOLT_RST      = 16'h0190;

    typedef enum logic [1:0] {
        AWS_LNK_WAIT = 2'b00,
        AWS_LNK_OK   = 2'b01,
        AWS_LNK_DEAD = 2'b10
    } aws_link_e;

endpackage

//--- hw/aws_hist_mem.sv
// Ten-entry warning history memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module aws_hist_mem
    import aws_pkg::*;
(
    // Clock
    input  wire logic                  sys_clk_in,
    // Write port
    input  wire logic                  wr_en_in,
    input  wire logic [AWS_HIST_AW-1:0] wr_addr_in,
    input  wire logic [7:0]            wr_data_in,
    // Read port
    input  wire logic [AWS_HIST_AW-1:0] rd_addr_in,
    output logic      [7:0]            rd_data_out
);

    typedef struct packed {
        logic [AWS_HIST_DEPTH-1:0][7:0] mem;
        logic [7:0]                     rd;
    } aws_mem_s;

    aws_mem_s st_reg;
    aws_mem_s st_next;

    always_comb begin
        st_next = st_reg;
        if (wr_en_in && (wr_addr_in < AWS_HIST_DEPTH_C)) begin
            st_next.mem[wr_addr_in] = wr_data_in;
        end
        st_next.rd = (rd_addr_in < AWS_HIST_DEPTH_C) ? st_reg.mem[rd_addr_in] : 8'h00;
    end

    // No reset: contents are volatile and only valid below the fill count
    always_ff @(posedge sys_clk_in) begin
        st_reg <= st_next;
    end

    assign rd_data_out = st_reg.rd;

endmodule // aws_hist_mem
`default_nettype wire

//--- hw/aws_supervisor.sv
// Alarm and warning supervisor with APB register access
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module aws_supervisor
    import aws_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Serial link status
    input  wire logic        frame_done_in,
    input  wire logic        framing_err_in,
    input  wire logic        block_check_character_err_in,
    input  wire logic [3:0]  rate_select_switch_in,
    input  wire logic        netconv_alarm_in,
    input  wire logic        alarm_clear_input_in,
    // Motor monitoring
    input  wire logic        motor_energized_in,
    input  wire logic [31:0] position_dev_in,
    input  wire logic [15:0] temperature_in,
    input  wire logic [15:0] supply_voltage_in,
    // Outputs
    output logic             alarm_out,
    output logic [7:0]       alarm_code_out,
    output logic [3:0]       alarm_blinks_out,
    output logic             motor_current_en_out,
    output logic             brake_engage_out,
    output logic             warning_output_out,
    output logic             irq_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                     alarm;
        logic [7:0]               alarm_code;
        logic                     deenergize;
        logic [7:0]               err_run;
        logic [7:0]               err_limit;
        logic [31:0]              timeout;
        logic [31:0]              tmo_cnt;
        aws_link_e                link;
        logic [31:0]              dev_on_lim;
        logic [31:0]              dev_off_lim;
        logic [15:0]              temp_lim;
        logic [15:0]              volt_lim;
        logic [2:0]               cfg;
        logic [7:0]               warn_prev;
        logic [AWS_HIST_AW-1:0]   head;
        logic [AWS_HIST_AW-1:0]   fill;
        logic [AWS_HIST_AW-1:0]   rd_idx;
        logic [AWS_IRQ_WIDTH-1:0] irq_stat;
        logic [AWS_IRQ_WIDTH-1:0] irq_mask;
        logic [31:0]              prdata;
        logic                     motor_en;
        logic                     brake;
        logic                     warn_out;
    } aws_state_s;

    aws_state_s st_reg;
    aws_state_s st_next;

    logic [7:0]             warn_code;
    logic                   hist_wr;
    logic [AWS_HIST_AW-1:0] hist_rd_addr;
    logic [7:0]             hist_rd_data;
    logic                   apb_wr;
    logic                   apb_rd;

    // Circular index arithmetic, used for both writing and reading
    function automatic logic [AWS_HIST_AW-1:0] hist_wrap(input logic [AWS_HIST_AW-1:0] a,
                                                         input logic [AWS_HIST_AW-1:0] b);
        logic [AWS_HIST_AW:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= {1'b0, AWS_HIST_DEPTH_C}) begin
            s = s - {1'b0, AWS_HIST_DEPTH_C};
        end
        return s[AWS_HIST_AW-1:0];
    endfunction

    // ------------------------------------------------------------------
    // Warning detection
    // ------------------------------------------------------------------
    // Highest-priority active warning; code 00h means none active
    always_comb begin
        warn_code = 8'h00;
        if (supply_voltage_in > st_reg.volt_lim) begin
            warn_code = AWS_WRN_VOLT;
        end
        if (temperature_in > st_reg.temp_lim) begin
            warn_code = AWS_WRN_HEAT;
        end
        if (!motor_energized_in && st_reg.cfg[AWS_CFG_AUTO_RET] &&
            (position_dev_in > st_reg.dev_off_lim)) begin
            warn_code = AWS_WRN_DEV_OFF;
        end
        if (motor_energized_in && (position_dev_in > st_reg.dev_on_lim)) begin
            warn_code = AWS_WRN_DEV_ON;
        end
    end

    // A new entry is logged when a warning appears or changes code
    assign hist_wr      = (warn_code != 8'h00) && (warn_code != st_reg.warn_prev);
    // Entry 0 is the newest: head points at it
    assign hist_rd_addr = hist_wrap(st_reg.head, st_reg.rd_idx);
    assign apb_wr       = psel_in && penable_in && pwrite_in;
    assign apb_rd       = psel_in && penable_in && !pwrite_in;

    // Volatile store; never initialised, so nothing survives power loss
    aws_hist_mem u_hist (
        .sys_clk_in  (sys_clk_in),
        .wr_en_in    (hist_wr),
        .wr_addr_in  (hist_wrap(st_reg.head, AWS_HIST_DEPTH_C - 4'h1)),
        .wr_data_in  (warn_code),
        .rd_addr_in  (hist_rd_addr),
        .rd_data_out (hist_rd_data)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // Link error run and timeout supervision
        if (frame_done_in) begin
            if (framing_err_in || block_check_character_err_in) begin
                if (st_reg.err_run != 8'hff) begin
                    st_next.err_run = st_reg.err_run + 8'h01;
                end
            end else begin
                st_next.err_run = 8'h00;
            end
        end

        case (st_reg.link)
            AWS_LNK_WAIT: begin
                if (frame_done_in && !framing_err_in && !block_check_character_err_in) begin
                    st_next.link = AWS_LNK_OK;
                end else if (st_reg.tmo_cnt >= st_reg.timeout) begin
                    st_next.link = AWS_LNK_DEAD;
                end else begin
                    st_next.tmo_cnt = st_reg.tmo_cnt + 32'h1;
                end
            end
            AWS_LNK_OK:   st_next.link = AWS_LNK_OK;
            AWS_LNK_DEAD: st_next.link = AWS_LNK_DEAD;
            default:      st_next.link = AWS_LNK_WAIT;
        endcase

        // Alarm capture: first alarm wins and latches until cleared
        if (!st_reg.alarm) begin
            if (rate_select_switch_in > AWS_RATE_MAX) begin
                st_next.alarm      = 1'b1;
                st_next.alarm_code = AWS_ALM_RATE;
                st_next.deenergize = 1'b1;
            end else if (st_reg.err_run != 8'h00 && st_reg.err_run == st_reg.err_limit) begin
                st_next.alarm      = 1'b1;
                st_next.alarm_code = AWS_ALM_LINK_ERR;
                st_next.deenergize = 1'b0;
            end else if (st_reg.link == AWS_LNK_DEAD) begin
                st_next.alarm      = 1'b1;
                st_next.alarm_code = AWS_ALM_TIMEOUT;
                st_next.deenergize = 1'b0;
            end else if (netconv_alarm_in) begin
                st_next.alarm      = 1'b1;
                st_next.alarm_code = AWS_ALM_NETCONV;
                st_next.deenergize = 1'b0;
            end
        end else if (alarm_clear_input_in && (st_reg.alarm_code != AWS_ALM_RATE)) begin
            // The rate switch alarm needs a power cycle
            st_next.alarm      = 1'b0;
            st_next.alarm_code = 8'h00;
            st_next.deenergize = 1'b0;
            st_next.err_run    = 8'h00;
            st_next.tmo_cnt    = 32'h0;
            st_next.link       = AWS_LNK_WAIT;
        end

        st_next.motor_en = !(st_next.alarm && st_next.deenergize);
        st_next.brake    = !st_next.motor_en && st_reg.cfg[AWS_CFG_BRAKE];
        st_next.warn_out = (warn_code != 8'h00);
        st_next.warn_prev = warn_code;

        // History bookkeeping
        if (hist_wr) begin
            st_next.head = hist_wrap(st_reg.head, AWS_HIST_DEPTH_C - 4'h1);
            if (st_reg.fill != AWS_HIST_DEPTH_C) begin
                st_next.fill = st_reg.fill + 4'h1;
            end
        end

        // Interrupts: set wins over the write-one clear
        if (apb_wr && paddr_in == AWS_OFS_IRQ_STAT) begin
            st_next.irq_stat = st_reg.irq_stat & ~pwdata_in[AWS_IRQ_WIDTH-1:0];
        end
        if (st_next.alarm && !st_reg.alarm) begin
            st_next.irq_stat[AWS_IRQ_ALARM] = 1'b1;
        end
        if (hist_wr) begin
            st_next.irq_stat[AWS_IRQ_WARN] = 1'b1;
        end

        // APB writes
        if (apb_wr) begin
            case (paddr_in)
                AWS_OFS_CONFIG:    st_next.cfg         = pwdata_in[2:0];
                AWS_OFS_ERR_LIMIT: st_next.err_limit   = pwdata_in[7:0];
                AWS_OFS_TIMEOUT:   st_next.timeout     = pwdata_in;
                AWS_OFS_DEV_ON:    st_next.dev_on_lim  = pwdata_in;
                AWS_OFS_DEV_OFF:   st_next.dev_off_lim = pwdata_in;
                AWS_OFS_TEMP_LIM:  st_next.temp_lim    = pwdata_in[15:0];
                AWS_OFS_VOLT_LIM:  st_next.volt_lim    = pwdata_in[15:0];
                AWS_OFS_IRQ_MASK:  st_next.irq_mask    = pwdata_in[AWS_IRQ_WIDTH-1:0];
                AWS_OFS_HIST_CMD: begin
                    if (pwdata_in[AWS_HCMD_CLEAR]) begin
                        st_next.fill   = 4'h0;
                        st_next.rd_idx = 4'h0;
                    end else begin
                        st_next.rd_idx = pwdata_in[AWS_HIST_AW-1:0];
                    end
                end
                default: st_next.cfg = st_reg.cfg;
            endcase
        end

        // APB read data, registered from the setup cycle
        st_next.prdata = 32'h0;
        case (paddr_in)
            AWS_OFS_ALARM:     st_next.prdata = {20'h0, alarm_blinks_out, st_reg.alarm_code};
            AWS_OFS_WARN:      st_next.prdata = {23'h0, st_reg.warn_out, warn_code};
            AWS_OFS_CONFIG:    st_next.prdata = {29'h0, st_reg.cfg};
            AWS_OFS_ERR_LIMIT: st_next.prdata = {24'h0, st_reg.err_limit};
            AWS_OFS_TIMEOUT:   st_next.prdata = st_reg.timeout;
            AWS_OFS_DEV_ON:    st_next.prdata = st_reg.dev_on_lim;
            AWS_OFS_DEV_OFF:   st_next.prdata = st_reg.dev_off_lim;
            AWS_OFS_TEMP_LIM:  st_next.prdata = {16'h0, st_reg.temp_lim};
            AWS_OFS_VOLT_LIM:  st_next.prdata = {16'h0, st_reg.volt_lim};
            AWS_OFS_HIST_CMD:  st_next.prdata = {24'h0, st_reg.fill, st_reg.rd_idx};
            AWS_OFS_HIST_DATA: st_next.prdata = (st_reg.rd_idx < st_reg.fill) ?
                                                {24'h0, hist_rd_data} : 32'h0;
            AWS_OFS_IRQ_STAT:  st_next.prdata = {30'h0, st_reg.irq_stat};
            AWS_OFS_IRQ_MASK:  st_next.prdata = {30'h0, st_reg.irq_mask};
            default:           st_next.prdata = 32'h0;
        endcase

        // Synchronous reset; history contents stay unknown, fill clears
        if (!rst_b_in) begin
            st_next             = '0;
            st_next.link        = AWS_LNK_WAIT;
            st_next.err_limit   = AWS_ERR_LIMIT_RST;
            st_next.timeout     = AWS_TIMEOUT_RST;
            st_next.dev_on_lim  = AWS_DEV_RST;
            st_next.dev_off_lim = AWS_DEV_RST;
            st_next.temp_lim    = AWS_TEMP_RST;
            st_next.volt_lim    = AWS_VOLT_RST;
            st_next.motor_en    = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Zero wait states: history data needs idle cycles after an index write
    assign pready_out           = 1'b1;
    assign pslverr_out          = 1'b0;
    assign prdata_out           = st_reg.prdata;
    assign alarm_out            = st_reg.alarm;
    assign alarm_code_out       = st_reg.alarm_code;
    assign alarm_blinks_out     = (st_reg.alarm_code == AWS_ALM_LINK_ERR) ?
                                  AWS_LINK_ERR_BLINKS : 4'h0;
    assign motor_current_en_out = st_reg.motor_en;
    assign brake_engage_out     = st_reg.brake;
    assign warning_output_out   = st_reg.warn_out;
    assign irq_out              = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule // aws_supervisor
`default_nettype wire

//--- testbench/aws_link_host.sv
// Host end of the serial link, reduced to received-frame status
`timescale 1ns/1ns
`default_nettype none
module aws_link_host (
    // Clock
    input  wire logic       sys_clk_in,
    // Frame request: kind 0 clean, 1 framing fault, 2 check fault
    input  wire logic       send_in,
    input  wire logic [1:0] kind_in,
    // Receiver status
    output logic            frame_done_out,
    output logic            framing_err_out,
    output logic            check_err_out
);
    logic toggle_reg = 1'b0;
    always_ff @(posedge sys_clk_in) begin
        toggle_reg <= ~toggle_reg;
        frame_done_out <= send_in;
        if (send_in) begin
            framing_err_out <= (kind_in == 2'h1);
            check_err_out <= (kind_in == 2'h2);
        end else begin
            // Flags mean nothing between frames, so they churn there
            framing_err_out <= toggle_reg;
            check_err_out <= ~toggle_reg;
        end
    end
endmodule // aws_link_host
`default_nettype wire

//--- testbench/aws_supervisor_checker.sv
// Port-level assertions for the supervisor
`timescale 1ns/1ns
`default_nettype none
module aws_supervisor_checker
    import aws_pkg::*;
(
    // Watched ports
    input wire logic        sys_clk_in,
    input wire logic        rst_b_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0]  rate_select_switch_in,
    input wire logic        netconv_alarm_in,
    input wire logic [15:0] temperature_in,
    input wire logic        alarm_out,
    input wire logic [7:0]  alarm_code_out,
    input wire logic [3:0]  alarm_blinks_out,
    input wire logic        motor_current_en_out,
    input wire logic        brake_engage_out,
    input wire logic        warning_output_out
);
    // Shadow of the overheat limit, kept from the bus writes
    logic [15:0] tlim_reg;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            tlim_reg <= AWS_TEMP_RST;
        end else if (psel_in && penable_in && pwrite_in && paddr_in == AWS_OFS_TEMP_LIM) begin
            tlim_reg <= pwdata_in[15:0];
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    property p_rate;
        rate_select_switch_in > AWS_RATE_MAX && !alarm_out
            |-> ##[1:2] alarm_out && alarm_code_out == AWS_ALM_RATE;
    endproperty
    a_rate: assert property (p_rate) else $error("no alarm on bad rate");
    property p_hold;
        alarm_out && alarm_code_out == AWS_ALM_RATE |=> alarm_out && $stable(alarm_code_out);
    endproperty
    a_hold: assert property (p_hold) else $error("rate alarm let go");
    property p_blinks;
        alarm_blinks_out == ((alarm_code_out == AWS_ALM_LINK_ERR) ? 4'h7 : 4'h0);
    endproperty
    a_blinks: assert property (p_blinks) else $error("blink count wrong");
    property p_net;
        netconv_alarm_in && !alarm_out |-> ##[1:2] alarm_out;
    endproperty
    a_net: assert property (p_net) else $error("converter alarm missed");
    property p_cut;
        alarm_out && alarm_code_out == AWS_ALM_RATE |=> !motor_current_en_out;
    endproperty
    a_cut: assert property (p_cut) else $error("current kept on cut alarm");
    property p_brake;
        brake_engage_out |-> !motor_current_en_out;
    endproperty
    a_brake: assert property (p_brake) else $error("brake with current on");
    property p_keep;
        alarm_out && alarm_code_out != AWS_ALM_RATE |-> motor_current_en_out;
    endproperty
    a_keep: assert property (p_keep) else $error("current cut on kept alarm");
    property p_heat;
        temperature_in > tlim_reg |-> ##[1:2] warning_output_out;
    endproperty
    a_heat: assert property (p_heat) else $error("overheat not flagged");
endmodule // aws_supervisor_checker
bind aws_supervisor aws_supervisor_checker chk_i (.sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .rate_select_switch_in(rate_select_switch_in),
    .netconv_alarm_in(netconv_alarm_in), .temperature_in(temperature_in),
    .alarm_out(alarm_out), .alarm_code_out(alarm_code_out),
    .alarm_blinks_out(alarm_blinks_out), .motor_current_en_out(motor_current_en_out),
    .brake_engage_out(brake_engage_out), .warning_output_out(warning_output_out));
`default_nettype wire

//--- testbench/alarm_warning_supervisor_test.sv
// Self-checking bench for the alarm and warning supervisor
`timescale 1ns/1ns
`default_nettype none
module alarm_warning_supervisor_test
    import aws_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, send = 1'b0;
    logic netc = 1'b0, aclr = 1'b0, en = 1'b1;
    logic [1:0] kind = 2'h0;
    logic [3:0] rate = 4'h0, blinks;
    logic [7:0] paddr = 8'h00, code;
    logic [15:0] temp = 16'h0000, volt = 16'h0000;
    logic [31:0] pwdata = 32'h0, pdev = 32'h0, prdata, q;
    logic pready, pslverr, fdone, ferr, cerr, alm, cur, brk, warn, irq, i0;
    int err_count = 0, cmp_count = 0;
    always #50 clk = ~clk;
    aws_supervisor dut (.sys_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .frame_done_in(fdone),
        .framing_err_in(ferr), .block_check_character_err_in(cerr),
        .rate_select_switch_in(rate), .netconv_alarm_in(netc), .alarm_clear_input_in(aclr),
        .motor_energized_in(en), .position_dev_in(pdev), .temperature_in(temp),
        .supply_voltage_in(volt), .alarm_out(alm), .alarm_code_out(code),
        .alarm_blinks_out(blinks), .motor_current_en_out(cur), .brake_engage_out(brk),
        .warning_output_out(warn), .irq_out(irq));
    aws_link_host host (.sys_clk_in(clk), .send_in(send), .kind_in(kind),
        .frame_done_out(fdone), .framing_err_out(ferr), .check_err_out(cerr));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task hang;
        err_count++;
        report_and_stop();
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        q = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic wait_for(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        if (n >= 60) hang();
    endtask
    task frame(input logic [1:0] k);
        send <= 1'b1;
        kind <= k;
        @(posedge clk);
        send <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task clr;
        aclr <= 1'b1;
        repeat (2) @(posedge clk);
        aclr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task do_reset;
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask
    task idx(input logic [31:0] i);
        apb(1'b1, AWS_OFS_HIST_CMD, i);
        // History data lags the index write
        repeat (2) @(posedge clk);
    endtask
    task settle;
        repeat (3) @(posedge clk);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_regs;
        rc(AWS_OFS_ERR_LIMIT, 32'h3);
        rc(AWS_OFS_DEV_ON, 32'h100);
        rc(AWS_OFS_DEV_OFF, 32'h100);
        rc(AWS_OFS_TEMP_LIM, 32'h55);
        rc(AWS_OFS_VOLT_LIM, 32'h190);
        rc(8'h40, 32'h0);
        chk(pslverr, 1'b0);
        chk(cur, 1'b1);
        $display("regs done");
    endtask
    task t_link;
        frame(2'h0);
        frame(2'h1);
        frame(2'h2);
        frame(2'h0);
        frame(2'h1);
        frame(2'h2);
        chk(alm, 1'b0);
        frame(2'h1);
        wait_for(alm);
        rc(AWS_OFS_ALARM, 32'h784);
        chk(cur, 1'b1);
        rc(AWS_OFS_IRQ_STAT, 32'h1);
        apb(1'b1, AWS_OFS_IRQ_MASK, 32'h0);
        i0 = irq;
        apb(1'b1, AWS_OFS_IRQ_MASK, 32'h3);
        chk(irq ^ i0, 1'b1);
        apb(1'b1, AWS_OFS_IRQ_STAT, 32'h1);
        rc(AWS_OFS_IRQ_STAT, 32'h0);
        chk(irq, 1'b0);
        clr();
        chk(alm, 1'b0);
        $display("link done");
    endtask
    task t_warn;
        pdev <= 32'h101;
        settle();
        rc(AWS_OFS_WARN, 32'h110);
        chk({alm, cur, warn}, 3'b011);
        pdev <= 32'h100;
        settle();
        chk(warn, 1'b0);
        en <= 1'b0;
        pdev <= 32'h101;
        settle();
        chk(warn, 1'b0);
        apb(1'b1, AWS_OFS_CONFIG, 32'h1);
        settle();
        rc(AWS_OFS_WARN, 32'h112);
        en <= 1'b1;
        pdev <= 32'h0;
        temp <= 16'h0056;
        settle();
        rc(AWS_OFS_WARN, 32'h121);
        temp <= 16'h0055;
        volt <= 16'h0191;
        settle();
        rc(AWS_OFS_WARN, 32'h122);
        volt <= 16'h0190;
        settle();
        chk(warn, 1'b0);
        $display("warn done");
    endtask
    task t_hist;
        idx(32'h10);
        idx(32'h0);
        rc(AWS_OFS_HIST_CMD, 32'h0);
        for (int i = 0; i < 6; i++) begin
            temp <= 16'h0056;
            volt <= 16'h0000;
            settle();
            temp <= 16'h0000;
            volt <= 16'h0191;
            settle();
        end
        volt <= 16'h0000;
        idx(32'h0);
        rc(AWS_OFS_HIST_CMD, 32'ha0);
        rc(AWS_OFS_HIST_DATA, 32'h22);
        idx(32'h1);
        rc(AWS_OFS_HIST_DATA, 32'h21);
        idx(32'h9);
        rc(AWS_OFS_HIST_DATA, 32'h21);
        idx(32'ha);
        rc(AWS_OFS_HIST_DATA, 32'h0);
        rc(AWS_OFS_IRQ_STAT, 32'h2);
        $display("history done");
    endtask
    task t_timeout;
        do_reset();
        chk({alm, cur, brk, warn, irq}, 5'b01000);
        rc(AWS_OFS_HIST_CMD, 32'h0);
        apb(1'b1, AWS_OFS_TIMEOUT, 32'd20);
        chk(alm, 1'b0);
        wait_for(alm);
        chk(code, AWS_ALM_TIMEOUT);
        chk(cur, 1'b1);
        frame(2'h0);
        clr();
        netc <= 1'b1;
        wait_for(alm);
        chk(code, AWS_ALM_NETCONV);
        netc <= 1'b0;
        clr();
        chk(alm, 1'b0);
        $display("timeout done");
    endtask
    task t_rate;
        apb(1'b1, AWS_OFS_CONFIG, 32'h2);
        rate <= 4'h4;
        settle();
        chk(alm, 1'b0);
        rate <= 4'h5;
        wait_for(alm);
        chk(code, AWS_ALM_RATE);
        settle();
        chk({cur, brk}, 2'b01);
        clr();
        chk(alm, 1'b1);
        $display("rate done");
    endtask
    initial begin
        do_reset();
        t_regs();
        t_link();
        t_warn();
        t_hist();
        t_timeout();
        t_rate();
        report_and_stop();
    end
endmodule // alarm_warning_supervisor_test
`default_nettype wire
